// [rtl/bal_alu.sv]
// arithmetic, logic and shift datapath with condition flag register
`include "bal_regs.svh"

// Overview of operation
// - decimal adjust byte result using held flags
// - unsigned 8x8 multiply, full 16-bit product
// - unsigned 16/8 divide, quotient and remainder
// - compare updates flags only, destination unchanged
// - word compare only register to register
// - negate byte as zero minus register
// - byte and with register or immediate
// - byte or with register or immediate
// - byte xor with register or immediate
// - byte one's complement of destination
// - arithmetic shift one bit, right keeps sign
// - logical shift one bit, zero fill
// - plain rotate one bit, end wraps around
// - rotate through carry as nine-bit ring
module bal_alu (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             op_valid,
    input  wire bal_pkg::bal_op_t op_sel,
    input  wire logic             op_word,
    input  wire logic             use_imm,
    input  wire logic [15:0]      dst_value,
    input  wire logic [15:0]      source_register,
    input  wire logic [7:0]       immediate_operand,
    input  wire logic             flags_load,
    input  wire logic [7:0]       flags_load_value,
    output logic                  busy,
    output logic                  result_valid,
    output logic                  result_write,
    output logic                  result_word,
    output logic [15:0]           result_value,
    output logic [7:0]            condition_flags_reg
);

    // ------------------------------------------------------------------
    // flag helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] nzvc_flags(
        input logic [7:0] f,
        input logic [7:0] v,
        input logic       vbit,
        input logic       cbit
    );
        logic [7:0] r;
        r = f;
        r[`BAL_FLAG_N] = v[7];
        r[`BAL_FLAG_Z] = (v == 8'h00);
        r[`BAL_FLAG_V] = vbit;
        r[`BAL_FLAG_C] = cbit;
        return r;
    endfunction : nzvc_flags

    // subtract a - b, byte or word, full flag set
    function automatic logic [7:0] sub_flags(
        input logic [7:0]  f,
        input logic [15:0] a,
        input logic [15:0] b,
        input logic        word
    );
        logic [16:0] d;
        logic [7:0]  r;
        d = {1'b0, a} - {1'b0, b};
        r = f;
        if (word) begin
            r[`BAL_FLAG_C] = d[16];
            r[`BAL_FLAG_N] = d[15];
            r[`BAL_FLAG_Z] = (d[15:0] == 16'h0000);
            r[`BAL_FLAG_V] = (a[15] ^ b[15]) & (a[15] ^ d[15]);
            r[`BAL_FLAG_H] = (a[11:0] < b[11:0]);
        end else begin
            r[`BAL_FLAG_C] = (a[7:0] < b[7:0]);
            r[`BAL_FLAG_N] = d[7];
            r[`BAL_FLAG_Z] = (d[7:0] == 8'h00);
            r[`BAL_FLAG_V] = (a[7] ^ b[7]) & (a[7] ^ d[7]);
            r[`BAL_FLAG_H] = (a[3:0] < b[3:0]);
        end
        return r;
    endfunction : sub_flags

    // ------------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------------
    bal_pkg::bal_state_t state;
    bal_pkg::bal_state_t next_state;
    logic [7:0]          divisor_hold;

    wire        take     = op_valid && (state == bal_pkg::bal_st_idle);
    wire [7:0]  dst_b    = dst_value[7:0];
    wire [7:0]  opnd_b   = use_imm ? immediate_operand : source_register[7:0];
    wire        flag_c   = condition_flags_reg[`BAL_FLAG_C];
    wire        flag_h   = condition_flags_reg[`BAL_FLAG_H];
    wire        flag_v   = condition_flags_reg[`BAL_FLAG_V];

    // word compare never takes the immediate path
    wire        cmp_word = op_word;
    wire [15:0] cmp_rhs  = cmp_word ? source_register
                                    : {8'h00, opnd_b};
    wire [15:0] cmp_lhs  = cmp_word ? dst_value : {8'h00, dst_b};

    // ------------------------------------------------------------------
    // decimal adjust
    // ------------------------------------------------------------------
    wire        bcd_hi_fix = flag_c || (dst_b > `BAL_BCD_BYTE_MAX);
    wire        bcd_lo_fix = flag_h || (dst_b[3:0] > `BAL_BCD_DIGIT_MAX);
    wire [7:0]  add_adj    = (bcd_hi_fix ? `BAL_BCD_HIGH_FIX : 8'h00)
                           | (bcd_lo_fix ? `BAL_BCD_LOW_FIX : 8'h00);
    wire [7:0]  sub_adj    = (flag_c ? `BAL_BCD_HIGH_FIX : 8'h00)
                           | (flag_h ? `BAL_BCD_LOW_FIX : 8'h00);
    wire [7:0]  daa_res    = dst_b + add_adj;
    wire [7:0]  das_res    = dst_b - sub_adj;

    // ------------------------------------------------------------------
    // multiply, negate, logic
    // ------------------------------------------------------------------
    wire [15:0] mul_res  = {8'h00, dst_b} * {8'h00, source_register[7:0]};
    wire [7:0]  neg_res  = 8'h00 - dst_b;
    wire [7:0]  and_res  = dst_b & opnd_b;
    wire [7:0]  or_res   = dst_b | opnd_b;
    wire [7:0]  xor_res  = dst_b ^ opnd_b;
    wire [7:0]  not_res  = ~dst_b;

    // ------------------------------------------------------------------
    // shifts and rotates
    // ------------------------------------------------------------------
    wire [7:0]  shl_res  = {dst_b[6:0], 1'b0};
    wire [7:0]  sar_res  = {dst_b[7], dst_b[7:1]};
    wire [7:0]  shr_res  = {1'b0, dst_b[7:1]};
    wire [7:0]  rol_res  = {dst_b[6:0], dst_b[7]};
    wire [7:0]  ror_res  = {dst_b[0], dst_b[7:1]};
    wire [7:0]  rxl_res  = {dst_b[6:0], flag_c};
    wire [7:0]  rxr_res  = {flag_c, dst_b[7:1]};
    wire        out_left = dst_b[7];
    wire        out_rght = dst_b[0];
    wire        arith_shift_left_op_ovf = dst_b[7] ^ dst_b[6];

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    logic        div_start;
    logic        div_done;
    logic [15:0] div_quot;
    logic [7:0]  div_rem;

    bal_div u_div (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .div_start (div_start),
        .dividend  (dst_value),
        .divisor   (source_register[7:0]),
        .div_done  (div_done),
        .quotient  (div_quot),
        .remainder (div_rem)
    );

    // ------------------------------------------------------------------
    // result and flag selection
    // ------------------------------------------------------------------
    logic [15:0] next_result;
    logic [7:0]  next_flags;
    logic        next_write;
    logic        next_word;
    logic        next_valid;

    always_comb begin
        next_result = result_value;
        next_flags  = condition_flags_reg;
        next_write  = 1'b0;
        next_word   = 1'b0;
        next_valid  = 1'b0;
        next_state  = state;
        div_start   = 1'b0;
        if (flags_load) begin
            next_flags = flags_load_value;
        end
        case (state)
            bal_pkg::bal_st_idle: begin
                if (take) begin
                    next_valid = 1'b1;
                    next_write = 1'b1;
                    case (op_sel)
                        bal_pkg::bal_decimal_adjust_after_add: begin
                            next_result = {8'h00, daa_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                daa_res, flag_v, bcd_hi_fix);
                        end
                        bal_pkg::bal_decimal_adjust_after_sub: begin
                            next_result = {8'h00, das_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                das_res, flag_v, flag_c);
                        end
                        bal_pkg::bal_unsigned_multiply_op: begin
                            next_result = mul_res;
                            next_word   = 1'b1;
                        end
                        bal_pkg::bal_unsigned_divide_op: begin
                            next_valid  = 1'b0;
                            next_write  = 1'b0;
                            div_start   = 1'b1;
                            next_state  = bal_pkg::bal_st_divide;
                        end
                        bal_pkg::bal_compare_op: begin
                            next_write  = 1'b0;
                            next_word   = cmp_word;
                            next_flags  = sub_flags(condition_flags_reg,
                                cmp_lhs, cmp_rhs, cmp_word);
                        end
                        bal_pkg::bal_negate_op: begin
                            next_result = {8'h00, neg_res};
                            next_flags  = sub_flags(condition_flags_reg,
                                16'h0000, {8'h00, dst_b}, 1'b0);
                        end
                        bal_pkg::bal_and_op: begin
                            next_result = {8'h00, and_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                and_res, 1'b0, flag_c);
                        end
                        bal_pkg::bal_or_op: begin
                            next_result = {8'h00, or_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                or_res, 1'b0, flag_c);
                        end
                        bal_pkg::bal_xor_op: begin
                            next_result = {8'h00, xor_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                xor_res, 1'b0, flag_c);
                        end
                        bal_pkg::bal_not_op: begin
                            next_result = {8'h00, not_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                not_res, 1'b0, flag_c);
                        end
                        bal_pkg::bal_arith_shift_left_op: begin
                            next_result = {8'h00, shl_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                shl_res, arith_shift_left_op_ovf, out_left);
                        end
                        bal_pkg::bal_arith_shift_right_op: begin
                            next_result = {8'h00, sar_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                sar_res, 1'b0, out_rght);
                        end
                        bal_pkg::bal_logic_shift_left_op: begin
                            next_result = {8'h00, shl_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                shl_res, 1'b0, out_left);
                        end
                        bal_pkg::bal_logic_shift_right_op: begin
                            next_result = {8'h00, shr_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                shr_res, 1'b0, out_rght);
                        end
                        bal_pkg::bal_rotate_left_op: begin
                            next_result = {8'h00, rol_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                rol_res, 1'b0, out_left);
                        end
                        bal_pkg::bal_rotate_right_op: begin
                            next_result = {8'h00, ror_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                ror_res, 1'b0, out_rght);
                        end
                        bal_pkg::bal_rotate_left_via_carry_op: begin
                            next_result = {8'h00, rxl_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                rxl_res, 1'b0, out_left);
                        end
                        bal_pkg::bal_rotate_right_via_carry_op: begin
                            next_result = {8'h00, rxr_res};
                            next_flags  = nzvc_flags(condition_flags_reg,
                                rxr_res, 1'b0, out_rght);
                        end
                        default: begin
                            next_valid = 1'b0;
                            next_write = 1'b0;
                        end
                    endcase
                end
            end
            bal_pkg::bal_st_divide: begin
                if (div_done) begin
                    next_result = {div_rem, div_quot[7:0]};
                    next_word   = 1'b1;
                    next_write  = 1'b1;
                    next_valid  = 1'b1;
                    next_flags[`BAL_FLAG_N] = divisor_hold[7];
                    next_flags[`BAL_FLAG_Z] = (divisor_hold == 8'h00);
                    next_state  = bal_pkg::bal_st_idle;
                end
            end
            default: begin
                next_state = bal_pkg::bal_st_idle;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state               <= bal_pkg::bal_st_idle;
            busy                <= 1'b0;
            result_valid        <= 1'b0;
            result_write        <= 1'b0;
            result_word         <= 1'b0;
            result_value        <= `BAL_RESULT_RESET;
            condition_flags_reg <= `BAL_FLAGS_RESET;
            divisor_hold        <= 8'h00;
        end else begin
            state               <= next_state;
            busy                <= (next_state == bal_pkg::bal_st_divide);
            result_valid        <= next_valid;
            result_write        <= next_write;
            result_word         <= next_word;
            result_value        <= next_result;
            condition_flags_reg <= next_flags;
            if (div_start) begin
                divisor_hold <= source_register[7:0];
            end
        end
    end

endmodule : bal_alu

// [shared/bal_regs.svh]
// flag positions, reset values and fixed counts of the byte alu datapath
`ifndef BAL_REGS_SVH
`define BAL_REGS_SVH

// ----------------------------------------------------------------------
// condition flag positions
// ----------------------------------------------------------------------
`define BAL_FLAG_C 0
`define BAL_FLAG_V 1
`define BAL_FLAG_Z 2
`define BAL_FLAG_N 3
`define BAL_FLAG_H 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BAL_FLAGS_RESET  8'h00
`define BAL_RESULT_RESET 16'h0000

// ----------------------------------------------------------------------
// decimal adjust constants
// ----------------------------------------------------------------------
`define BAL_BCD_LOW_FIX   8'h06
`define BAL_BCD_HIGH_FIX  8'h60
`define BAL_BCD_BYTE_MAX  8'h99
`define BAL_BCD_DIGIT_MAX 4'h9

// ----------------------------------------------------------------------
// divider step count
// ----------------------------------------------------------------------
`define BAL_DIV_STEPS 5'h10

`endif

// [shared/bal_pkg.sv]
// types shared by the byte alu datapath
package bal_pkg;

    // ------------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        bal_decimal_adjust_after_add  = 5'h00,
        bal_decimal_adjust_after_sub  = 5'h01,
        bal_unsigned_multiply_op      = 5'h02,
        bal_unsigned_divide_op        = 5'h03,
        bal_compare_op                = 5'h04,
        bal_negate_op                 = 5'h05,
        bal_and_op                    = 5'h06,
        bal_or_op                     = 5'h07,
        bal_xor_op                    = 5'h08,
        bal_not_op                    = 5'h09,
        bal_arith_shift_left_op       = 5'h0a,
        bal_arith_shift_right_op      = 5'h0b,
        bal_logic_shift_left_op       = 5'h0c,
        bal_logic_shift_right_op      = 5'h0d,
        bal_rotate_left_op            = 5'h0e,
        bal_rotate_right_op           = 5'h0f,
        bal_rotate_left_via_carry_op  = 5'h10,
        bal_rotate_right_via_carry_op = 5'h11
    } bal_op_t;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        bal_st_idle   = 2'b01,
        bal_st_divide = 2'b10
    } bal_state_t;

endpackage : bal_pkg

// [rtl/bal_div.sv]
// restoring 16 by 8 unsigned divider, one quotient bit per clock
`include "bal_regs.svh"

module bal_div (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        div_start,
    input  wire logic [15:0] dividend,
    input  wire logic [7:0]  divisor,
    output logic             div_done,
    output logic [15:0]      quotient,
    output logic [7:0]       remainder
);

    logic [7:0] div_by;
    logic [4:0] steps_left;
    logic       running;

    // ------------------------------------------------------------------
    // one restoring step
    // ------------------------------------------------------------------
    wire  [8:0] partial    = {remainder, quotient[15]};
    wire        fits       = partial >= {1'b0, div_by};
    wire  [8:0] trial      = partial - {1'b0, div_by};
    wire  [7:0] next_rem   = fits ? trial[7:0] : partial[7:0];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_by     <= 8'h00;
            steps_left <= 5'h00;
            running    <= 1'b0;
            div_done   <= 1'b0;
            quotient   <= 16'h0000;
            remainder  <= 8'h00;
        end else begin
            div_done <= 1'b0;
            if (div_start && !running) begin
                div_by     <= divisor;
                quotient   <= dividend;
                remainder  <= 8'h00;
                steps_left <= `BAL_DIV_STEPS;
                running    <= 1'b1;
            end else if (running) begin
                quotient   <= {quotient[14:0], fits};
                remainder  <= next_rem;
                steps_left <= steps_left - 5'h01;
                if (steps_left == 5'h01) begin
                    running  <= 1'b0;
                    div_done <= 1'b1;
                end
            end
        end
    end

endmodule : bal_div

// [test/bal_alu_asserts.sv]
// port checks of the byte alu datapath
module bal_alu_asserts (
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    input wire logic             op_valid,
    input wire bal_pkg::bal_op_t op_sel,
    input wire logic             use_imm,
    input wire logic [15:0]      dst_value,
    input wire logic [15:0]      source_register,
    input wire logic [7:0]       immediate_operand,
    input wire logic             busy,
    input wire logic             result_valid,
    input wire logic             result_write,
    input wire logic [15:0]      result_value,
    input wire logic [7:0]       condition_flags_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic       tk = op_valid && !busy;
    wire logic [7:0] d  = dst_value[7:0];
    wire logic [7:0] b  = use_imm ? immediate_operand : source_register[7:0];
    wire logic [7:0] r  = result_value[7:0];
    a_mul_product: assert property (
        tk && op_sel == bal_pkg::bal_unsigned_multiply_op |=>
        result_value == $past(d) * $past(source_register[7:0]))
        else $error("multiply product wrong");
    a_cmp_no_write: assert property (
        tk && op_sel == bal_pkg::bal_compare_op |=>
        result_valid && !result_write && $stable(result_value))
        else $error("compare wrote its destination");
    a_neg_twos: assert property (
        tk && op_sel == bal_pkg::bal_negate_op |=> r == 8'h00 - $past(d))
        else $error("negate wrong");
    a_and_byte: assert property (
        tk && op_sel == bal_pkg::bal_and_op |=> r == ($past(d) & $past(b)))
        else $error("and wrong");
    a_or_byte: assert property (
        tk && op_sel == bal_pkg::bal_or_op |=> r == ($past(d) | $past(b)))
        else $error("or wrong");
    a_xor_byte: assert property (
        tk && op_sel == bal_pkg::bal_xor_op |=> r == ($past(d) ^ $past(b)))
        else $error("xor wrong");
    a_not_byte: assert property (
        tk && op_sel == bal_pkg::bal_not_op |=> r == ~$past(d))
        else $error("complement wrong");
    a_arith_shift_right_op_sign: assert property (
        tk && op_sel == bal_pkg::bal_arith_shift_right_op |=>
        r[7:6] == {2{$past(d[7])}} && condition_flags_reg[0] == $past(d[0]))
        else $error("arithmetic right shift lost sign");
    a_logic_shift_right_op_fill: assert property (
        tk && op_sel == bal_pkg::bal_logic_shift_right_op |=>
        r == {1'b0, $past(d[7:1])})
        else $error("logical right shift fill wrong");
    a_rotate_left_op_wrap: assert property (
        tk && op_sel == bal_pkg::bal_rotate_left_op |=>
        r == {$past(d[6:0]), $past(d[7])})
        else $error("rotate left wrong");
    a_div_answer: assert property (
        tk && op_sel == bal_pkg::bal_unsigned_divide_op |=>
        busy ##[15:17] result_valid)
        else $error("divide answer late");
    c_mul: cover property (tk && op_sel == bal_pkg::bal_unsigned_multiply_op);
    c_div: cover property (tk && op_sel == bal_pkg::bal_unsigned_divide_op);
    c_cmp: cover property (tk && op_sel == bal_pkg::bal_compare_op);
endmodule : bal_alu_asserts

bind bal_alu bal_alu_asserts u_chk (.*);

// [test/bal_reg_model.sv]
// destination register kept by the decoder side
module bal_reg_model (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        result_valid,
    input wire logic        result_write,
    input wire logic [15:0] result_value,
    output logic [15:0]     dst_reg
);
    // write back only when the datapath asks
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dst_reg <= 16'h0000;
        end else if (result_valid && result_write) begin
            dst_reg <= result_value;
        end
    end
endmodule : bal_reg_model

// [test/byte_alu_arith_logic_shift_tb.sv]
// self-checking bench of the byte alu datapath
module byte_alu_arith_logic_shift_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic             ref_clk = 0, sys_rst = 1, op_valid = 0, op_word = 0;
    logic             use_imm = 0, flags_load = 0;
    logic             busy, result_valid, result_write, result_word;
    bal_pkg::bal_op_t op_sel = bal_pkg::bal_and_op;
    logic [15:0]      dst_value = 0, source_register = 0;
    logic [15:0]      result_value, dst_reg;
    logic [7:0]       immediate_operand = 0, flags_load_value = 0;
    logic [7:0]       condition_flags_reg;
    int               miscompares = 0, checks_done = 0, cycles = 0;
    bal_alu dut (.*);
    bal_reg_model partner (.*);
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(logic ok, string what);
        checks_done++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk
    function automatic logic [16:0] exp_of(bal_pkg::bal_op_t op,
        logic [15:0] d, s, logic [7:0] b, f, logic wd);
        logic [7:0]  v;
        logic [16:0] e;
        v = d[7:0];
        e = 17'h0_0000;
        case (op)
            bal_pkg::bal_decimal_adjust_after_add: begin
                v = v + ((f[0] || d[7:0] > 8'h99) ? 8'h60 : 8'h00);
                e[7:0] = v + ((f[5] || d[3:0] > 4'h9) ? 8'h06 : 8'h00);
            end
            bal_pkg::bal_decimal_adjust_after_sub: begin
                v = v - (f[0] ? 8'h60 : 8'h00);
                e[7:0] = v - (f[5] ? 8'h06 : 8'h00);
            end
            bal_pkg::bal_unsigned_multiply_op: e[15:0] = d[7:0] * s[7:0];
            bal_pkg::bal_unsigned_divide_op:
                e[15:0] = {8'(d % s[7:0]), 8'(d / s[7:0])};
            bal_pkg::bal_compare_op: e[16] = wd ? d < s : v < b;
            bal_pkg::bal_negate_op: e[7:0] = 8'h00 - v;
            bal_pkg::bal_and_op: e[7:0] = v & b;
            bal_pkg::bal_or_op: e[7:0] = v | b;
            bal_pkg::bal_xor_op: e[7:0] = v ^ b;
            bal_pkg::bal_not_op: e[7:0] = ~v;
            bal_pkg::bal_arith_shift_right_op: e = {v[0], 8'h00, v[7], v[7:1]};
            bal_pkg::bal_logic_shift_right_op: e = {v[0], 8'h00, 1'b0, v[7:1]};
            bal_pkg::bal_rotate_left_op: e = {v[7], 8'h00, v[6:0], v[7]};
            bal_pkg::bal_rotate_right_op: e = {v[0], 8'h00, v[0], v[7:1]};
            bal_pkg::bal_rotate_left_via_carry_op:
                e = {v[7], 8'h00, v[6:0], f[0]};
            bal_pkg::bal_rotate_right_via_carry_op:
                e = {v[0], 8'h00, f[0], v[7:1]};
            default: e = {v[7], 8'h00, v[6:0], 1'b0};
        endcase
        return e;
    endfunction : exp_of
    task automatic run(bal_pkg::bal_op_t op, logic [15:0] d, s,
        logic [7:0] im, logic ui, wd);
        logic [16:0] e;
        logic [15:0] keep;
        logic [7:0]  f;
        f = 8'($urandom);
        e = exp_of(op, d, s, ui ? im : s[7:0], f, wd);
        @(posedge ref_clk) #1;
        flags_load = 1;
        flags_load_value = f;
        @(posedge ref_clk) #1;
        keep = dst_reg;
        flags_load = 0;
        op_valid = 1;
        op_sel = op;
        {op_word, use_imm} = {wd, ui};
        {dst_value, source_register, immediate_operand} = {d, s, im};
        @(posedge ref_clk) #1;
        op_valid = 0;
        for (int i = 0; i < 30 && result_valid !== 1'b1; i++) begin
            @(posedge ref_clk) #1;
        end
        chk(result_valid === 1'b1, "no answer");
        chk(result_word === (wd ||
            op == bal_pkg::bal_unsigned_multiply_op ||
            op == bal_pkg::bal_unsigned_divide_op), "word");
        chk(result_write === (op != bal_pkg::bal_compare_op), "write");
        if (op == bal_pkg::bal_compare_op || op > bal_pkg::bal_not_op) begin
            chk(condition_flags_reg[0] === e[16], "carry");
        end
        if (op > bal_pkg::bal_compare_op) begin
            chk(condition_flags_reg[3:2] ===
                {e[7], e[7:0] == 8'h00}, "n z");
        end
        @(posedge ref_clk) #1;
        chk(dst_reg === (op == bal_pkg::bal_compare_op ?
            keep : e[15:0]), "dst");
    endtask : run
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        bal_pkg::bal_op_t op;
        logic [15:0]      d, s;
        logic             wd, ui;
        void'($urandom(32'h00bc));
        repeat (8) @(posedge ref_clk);
        #1 sys_rst = 0;
        run(bal_pkg::bal_unsigned_multiply_op, 16'hffff, 16'h00ff,
            8'h00, 0, 0);
        run(bal_pkg::bal_unsigned_divide_op, 16'hfeff, 16'h00ff,
            8'h00, 0, 0);
        run(bal_pkg::bal_negate_op, 16'h0080, 16'h0000,
            8'h00, 0, 0);
        run(bal_pkg::bal_compare_op, 16'h1234, 16'h1235,
            8'h00, 0, 1);
        for (int i = 0; i < 90; i++) begin
            op = bal_pkg::bal_op_t'(i % 18);
            d = 16'($urandom);
            s = 16'($urandom);
            if (op == bal_pkg::bal_unsigned_divide_op) begin
                s = {8'h00, s[7:1], 1'b1};
                d[15:8] = 8'($urandom % s[7:0]);
            end
            wd = op == bal_pkg::bal_compare_op && $urandom % 2;
            ui = !wd && $urandom % 2;
            run(op, d, s, 8'($urandom), ui, wd);
        end
        wrap_up();
    end
endmodule : byte_alu_arith_logic_shift_tb
